// [src/pfn_pkg.sv]
// Constants and types for the link training and code negotiation block
// Assumes a 25 MHz core clock and an AXI4-Lite register master
// Operation
// [R1] Channel optimize state is always visited
// [R2] Equalization exchanged in-band during channel optimize
// [R3] Exchange follows four-level PMD training protocol
// [R4] Idle state is mandatory in the sequence
// [R5] Self-test state optional, uses modified sequences
// [R6] Code chosen from sent and received advertisements
// [R7] Flags at bits 31,30 and 15,14, rest zero
// [R8] Software mask withholds short-code flag
// [R9] Both short: choose 288-bit BCH code
// [R10] Else both long: choose 320-bit BCH code
// [R11] No common code: fail, back to signal detect
// [R12] Clock compensation tolerates 200 ppm offset
// [R13] Controls disable or rescale compensation sequences
// [R14] No forwarded clock, recovered from data
// [R15] Short-code mask is control bit 3
// [R16] Nonzero override bits 2:0 bypass negotiation; code bypasses only for values 1 to 4, values 5 to 7 negotiate
// [R17] Capture remote field, select once, hold
// [R18] Remote flag set if either copy set
package pfn_pkg;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
	localparam int CTRL_OVR_LSB = 0;
	localparam int CTRL_MASK_SHORT = 3;
	localparam int CTRL_CC_DIS = 8;
	localparam int CTRL_CC_SCALE_LSB = 9;
	localparam int CTRL_SELFTEST_EN = 11;
	localparam int CTRL_START = 12;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int ADV_LONG_HI = 31;
	localparam int ADV_SHORT_HI = 30;
	localparam int ADV_LONG_LO = 15;
	localparam int ADV_SHORT_LO = 14;
	localparam logic [2:0] CODE_SHORT = 3'h0;
	localparam logic [2:0] CODE_LONG = 3'h1;
	localparam logic [2:0] CODE_CRC = 3'h2;
	localparam logic [2:0] CODE_RS = 3'h3;
	localparam logic [2:0] OVR_NONE = 3'h0;
	localparam logic [2:0] OVR_SHORT = 3'h1;
	localparam logic [2:0] OVR_LONG = 3'h2;
	localparam logic [2:0] OVR_CRC = 3'h3;
	localparam logic [2:0] OVR_RS = 3'h4;
	localparam int IRQ_UP = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_W = 2;
	localparam int CC_BASE_UI = 131072;
	localparam int UI_PER_CLK = 2048;
	localparam logic [15:0] CC_BASE_CYC = 16'(CC_BASE_UI / UI_PER_CLK);
	localparam int LOCAL_CC_COUNT_W = 16;
	typedef enum logic [2:0] {
		PFN_IDLE, PFN_DETECT, PFN_OPTIM, PFN_ALIGN, PFN_SELFTEST,
		PFN_CONFIG, PFN_UP
	} pfn_state_type;
endpackage : pfn_pkg

// [src/pfn_adv_select.sv]
// Builds the local advertisement and chooses the code
// Assumes remote field is already captured and stable
`timescale 1ns/1ns
module pfn_adv_select (
	input wire logic mask_short_in,
	input wire logic local_short_in,
	input wire logic local_long_in,
	input wire logic [2:0] override_in,
	input wire logic [31:0] remote_adv_in,
	output logic [31:0] local_adv_out,
	output logic [2:0] code_out,
	output logic ok_out
);
	logic sh;
	logic lg;
	logic r_sh;
	logic r_lg;
	always_comb begin
		sh = local_short_in & ~mask_short_in; // [R8] [R15]
		lg = local_long_in;
		local_adv_out = 32'h0000_0000; // [R7]
		local_adv_out[pfn_pkg::ADV_LONG_HI] = lg;
		local_adv_out[pfn_pkg::ADV_SHORT_HI] = sh;
		local_adv_out[pfn_pkg::ADV_LONG_LO] = lg;
		local_adv_out[pfn_pkg::ADV_SHORT_LO] = sh;
		r_sh = remote_adv_in[pfn_pkg::ADV_SHORT_HI] |
			remote_adv_in[pfn_pkg::ADV_SHORT_LO]; // [R18]
		r_lg = remote_adv_in[pfn_pkg::ADV_LONG_HI] |
			remote_adv_in[pfn_pkg::ADV_LONG_LO];
		ok_out = 1'b1;
		code_out = pfn_pkg::CODE_SHORT;
		case (override_in) // [R16]
		pfn_pkg::OVR_SHORT: code_out = pfn_pkg::CODE_SHORT;
		pfn_pkg::OVR_LONG: code_out = pfn_pkg::CODE_LONG;
		pfn_pkg::OVR_CRC: code_out = pfn_pkg::CODE_CRC;
		pfn_pkg::OVR_RS: code_out = pfn_pkg::CODE_RS;
		default: begin
			if (sh & r_sh) begin // [R6] [R9]
				code_out = pfn_pkg::CODE_SHORT;
			end else if (lg & r_lg) begin // [R10]
				code_out = pfn_pkg::CODE_LONG;
			end else begin
				ok_out = 1'b0; // [R11]
			end
		end
		endcase
	end
endmodule : pfn_adv_select

// [src/pfn_train.sv]
// Training sequencer, code negotiation and AXI4-Lite register slave
// Assumes lane PHY reports phase completion as synchronous levels/pulses
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module pfn_train (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic local_short_in,
	input wire logic local_long_in,
	input wire logic signal_detect_in,
	input wire logic cdr_lock_in,
	input wire logic eq_done_in,
	input wire logic align_done_in,
	input wire logic selftest_done_in,
	input wire logic remote_adv_valid_in,
	input wire logic [31:0] remote_adv_in,
	output logic [31:0] local_adv_out,
	output logic [2:0] state_out,
	output logic eq_exchange_out,
	output logic selftest_seq_out,
	output logic cc_send_out,
	output logic [2:0] code_out,
	output logic link_up_out,
	output logic irq_out
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic have_aw;
		logic have_w;
		logic [3:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] ctrl;
		logic [pfn_pkg::IRQ_W-1:0] istat;
		logic [pfn_pkg::IRQ_W-1:0] imask;
		pfn_pkg::pfn_state_type st;
		logic [31:0] remote;
		logic got;
		logic [31:0] ladv;
		logic [2:0] code;
		logic up;
		logic irq;
		logic eqx;
		logic stseq;
		logic [17:0] cc_cnt;
		logic cc;
	} pfn_regs_type;

	pfn_regs_type r;
	pfn_regs_type next_r;
	logic [31:0] adv_w;
	logic [2:0] sel_code;
	logic sel_ok;
	logic [17:0] cc_limit;
	logic [pfn_pkg::IRQ_W-1:0] ev;
	logic [pfn_pkg::IRQ_W-1:0] clr;

	pfn_adv_select u_sel (
		.mask_short_in(r.ctrl[pfn_pkg::CTRL_MASK_SHORT]),
		.local_short_in(local_short_in),
		.local_long_in(local_long_in),
		.override_in(r.ctrl[2:0]),
		.remote_adv_in(r.remote),
		.local_adv_out(adv_w),
		.code_out(sel_code),
		.ok_out(sel_ok)
	);

	// Compensation interval scaled by control: x1, x2, x4, /2 [R13]
	always_comb begin
		case (r.ctrl[pfn_pkg::CTRL_CC_SCALE_LSB +: 2])
		2'h1: cc_limit = {1'b0, pfn_pkg::CC_BASE_CYC, 1'b0};
		2'h2: cc_limit = {pfn_pkg::CC_BASE_CYC, 2'h0};
		2'h3: cc_limit = {3'h0, pfn_pkg::CC_BASE_CYC[15:1]};
		default: cc_limit = {2'h0, pfn_pkg::CC_BASE_CYC};
		endcase
	end

	always_comb begin
		next_r = r;
		ev = '0;
		clr = '0;
		next_r.ladv = adv_w;
		// Write channel, address and data in either order
		if (s_axi_awvalid && r.awready) begin
			next_r.awready = 1'b0;
			next_r.have_aw = 1'b1;
			next_r.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r.wready) begin
			next_r.wready = 1'b0;
			next_r.have_w = 1'b1;
			next_r.wdata = s_axi_wdata;
			next_r.wstrb = s_axi_wstrb;
		end
		if (r.have_aw && r.have_w && !r.bvalid) begin
			next_r.have_aw = 1'b0;
			next_r.have_w = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = 2'h0;
			case (r.waddr)
			pfn_pkg::ADDR_CTRL: begin
				for (int i = 0; i < 4; i++) begin
					if (r.wstrb[i]) begin
						next_r.ctrl[i*8 +: 8] = r.wdata[i*8 +: 8];
					end
				end
			end
			pfn_pkg::ADDR_IRQ_STAT: begin
				if (r.wstrb[0]) begin
					clr = r.wdata[pfn_pkg::IRQ_W-1:0];
				end
			end
			pfn_pkg::ADDR_IRQ_MASK: begin
				if (r.wstrb[0]) begin
					next_r.imask = r.wdata[pfn_pkg::IRQ_W-1:0];
				end
			end
			pfn_pkg::ADDR_STATUS: next_r.bresp = 2'h2;
			default: next_r.bresp = 2'h2;
			endcase
		end
		if (r.bvalid && s_axi_bready) begin
			next_r.bvalid = 1'b0;
			next_r.awready = 1'b1;
			next_r.wready = 1'b1;
		end
		// Read channel
		if (s_axi_arvalid && r.arready) begin
			next_r.arready = 1'b0;
			next_r.rvalid = 1'b1;
			next_r.rresp = 2'h0;
			case (s_axi_araddr)
			pfn_pkg::ADDR_CTRL: next_r.rdata = r.ctrl;
			pfn_pkg::ADDR_STATUS: next_r.rdata = {r.remote[31:30],
				r.remote[15:14], 20'h0, r.code, r.up, 1'b0, 3'(r.st)};
			pfn_pkg::ADDR_IRQ_STAT: next_r.rdata = {30'h0, r.istat};
			pfn_pkg::ADDR_IRQ_MASK: next_r.rdata = {30'h0, r.imask};
			default: begin
				next_r.rdata = 32'h0000_0000;
				next_r.rresp = 2'h2;
			end
			endcase
		end
		if (r.rvalid && s_axi_rready) begin
			next_r.rvalid = 1'b0;
			next_r.arready = 1'b1;
		end
		// Training sequence
		next_r.eqx = 1'b0;
		next_r.stseq = 1'b0;
		case (r.st)
		pfn_pkg::PFN_IDLE: begin // [R4]
			next_r.up = 1'b0;
			if (r.ctrl[pfn_pkg::CTRL_START]) begin
				next_r.st = pfn_pkg::PFN_DETECT;
			end
		end
		pfn_pkg::PFN_DETECT: begin
			// Clock recovered from lane data only [R14]
			if (signal_detect_in && cdr_lock_in) begin
				next_r.st = pfn_pkg::PFN_OPTIM; // [R1]
			end
		end
		pfn_pkg::PFN_OPTIM: begin
			next_r.eqx = 1'b1; // [R2] [R3]
			if (eq_done_in) begin
				next_r.st = pfn_pkg::PFN_ALIGN;
				next_r.eqx = 1'b0;
			end
		end
		pfn_pkg::PFN_ALIGN: begin
			if (align_done_in) begin
				next_r.st = r.ctrl[pfn_pkg::CTRL_SELFTEST_EN] ?
					pfn_pkg::PFN_SELFTEST : pfn_pkg::PFN_CONFIG; // [R5]
			end
		end
		pfn_pkg::PFN_SELFTEST: begin
			next_r.stseq = 1'b1; // [R5]
			if (selftest_done_in) begin
				next_r.st = pfn_pkg::PFN_CONFIG;
				next_r.stseq = 1'b0;
			end
		end
		pfn_pkg::PFN_CONFIG: begin
			// Decide after capture, or at once with override 1 to 4, so an all-zero field also fails unless overridden
			if (remote_adv_valid_in) begin
				next_r.remote = remote_adv_in; // [R17]
				next_r.got = 1'b1;
			end else if (r.got || (r.ctrl[2:0] != pfn_pkg::OVR_NONE &&
				r.ctrl[2:0] <= pfn_pkg::OVR_RS)) begin
				next_r.got = 1'b0;
				if (sel_ok) begin
					next_r.code = sel_code; // [R17]
					next_r.up = 1'b1;
					next_r.st = pfn_pkg::PFN_UP;
					ev[pfn_pkg::IRQ_UP] = 1'b1;
				end else begin
					next_r.st = pfn_pkg::PFN_DETECT; // [R11]
					next_r.remote = 32'h0;
					ev[pfn_pkg::IRQ_FAIL] = 1'b1;
				end
			end
		end
		pfn_pkg::PFN_UP: begin
			if (!signal_detect_in || !r.ctrl[pfn_pkg::CTRL_START]) begin
				next_r.up = 1'b0;
				next_r.remote = 32'h0;
				next_r.st = pfn_pkg::PFN_IDLE;
			end
		end
		default: next_r.st = pfn_pkg::PFN_IDLE;
		endcase
		// Periodic compensation insertion from align onward [R12]
		next_r.cc = 1'b0;
		if (r.st == pfn_pkg::PFN_IDLE || r.st == pfn_pkg::PFN_DETECT ||
			r.st == pfn_pkg::PFN_OPTIM ||
			r.ctrl[pfn_pkg::CTRL_CC_DIS]) begin // [R13]
			next_r.cc_cnt = '0;
		end else if (r.cc_cnt + 18'h1 >= cc_limit) begin
			next_r.cc_cnt = '0;
			next_r.cc = 1'b1;
		end else begin
			next_r.cc_cnt = r.cc_cnt + 18'h1;
		end
		// Set wins over clear
		next_r.istat = (r.istat & ~clr) | ev;
		// Mask bit set blocks its event
		next_r.irq = |(next_r.istat & ~next_r.imask);
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '0;
			r.awready <= 1'b1;
			r.wready <= 1'b1;
			r.arready <= 1'b1;
			r.ctrl <= pfn_pkg::CTRL_RESET;
			r.st <= pfn_pkg::PFN_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign local_adv_out = r.ladv;
	assign state_out = 3'(r.st);
	assign eq_exchange_out = r.eqx;
	assign selftest_seq_out = r.stseq;
	assign cc_send_out = r.cc;
	assign code_out = r.code;
	assign link_up_out = r.up;
	assign irq_out = r.irq;

	sequence s_cfg_fail;
		r.st == pfn_pkg::PFN_CONFIG && ev[pfn_pkg::IRQ_FAIL];
	endsequence

	a_optim_visit: assert property (@(posedge clock_in) // [R1]
		disable iff (!nrst_in)
		r.st == pfn_pkg::PFN_DETECT && next_r.st != pfn_pkg::PFN_DETECT
		|=> r.st == pfn_pkg::PFN_OPTIM) else $error("optimize skipped");
	a_eq_active: assert property (@(posedge clock_in) // [R2]
		disable iff (!nrst_in)
		r.st == pfn_pkg::PFN_OPTIM && $past(r.st) == pfn_pkg::PFN_OPTIM
		|-> r.eqx) else $error("no eq exchange");
	a_adv_zero: assert property (@(posedge clock_in) // [R7]
		disable iff (!nrst_in)
		(local_adv_out & 32'h3fff_3fff) == 32'h0 &&
		local_adv_out[31:30] == local_adv_out[15:14])
		else $error("bad advertisement");
	a_mask_short: assert property (@(posedge clock_in) // [R8]
		disable iff (!nrst_in)
		$past(r.ctrl[3]) |-> !local_adv_out[30] && !local_adv_out[14])
		else $error("short not masked");
	a_fail_back: assert property (@(posedge clock_in) // [R11]
		disable iff (!nrst_in)
		s_cfg_fail |=> !r.up && !r.got && r.remote == 32'h0)
		else $error("fail left stale state");
	a_fail_state: assert property (@(posedge clock_in) // [R11]
		disable iff (!nrst_in)
		s_cfg_fail |=> r.st == pfn_pkg::PFN_DETECT)
		else $error("fail not to detect");
	a_up_hold: assert property (@(posedge clock_in) // [R17]
		disable iff (!nrst_in)
		r.st == pfn_pkg::PFN_UP && $past(r.st) == pfn_pkg::PFN_UP
		|-> $stable(r.code)) else $error("code changed while up");
	a_cc_off: assert property (@(posedge clock_in) // [R13]
		disable iff (!nrst_in)
		r.ctrl[pfn_pkg::CTRL_CC_DIS] ##1 r.ctrl[pfn_pkg::CTRL_CC_DIS]
		|-> !r.cc) else $error("comp sent while disabled");
	a_ovr_code: assert property (@(posedge clock_in) // [R16]
		disable iff (!nrst_in)
		ev[pfn_pkg::IRQ_UP] && r.ctrl[2:0] == pfn_pkg::OVR_RS
		|=> r.code == pfn_pkg::CODE_RS) else $error("override ignored");
endmodule : pfn_train

// [test/pfn_peer.sv]
// Remote peer model: answers each training phase and sends its advertisement
// Assumes the shared core clock and the state codes of pfn_pkg
`timescale 1ns/1ns
module pfn_peer (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic [2:0] state_in,
	input wire logic [3:0] delay_in,
	input wire logic [31:0] adv_in,
	output logic detect_out,
	output logic eq_done_out,
	output logic align_done_out,
	output logic st_done_out,
	output logic adv_valid_out,
	output logic [31:0] adv_out
);
	logic [2:0] prev;
	logic [7:0] cnt;
	logic ready;
	logic in_cfg;
	assign ready = cnt >= {4'h0, delay_in};
	assign in_cfg = state_in == pfn_pkg::PFN_CONFIG;
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			prev <= 3'h0;
			cnt <= 8'h00;
			detect_out <= 1'b0;
			eq_done_out <= 1'b0;
			align_done_out <= 1'b0;
			st_done_out <= 1'b0;
			adv_valid_out <= 1'b0;
			adv_out <= 32'h0;
		end else begin
			prev <= state_in;
			cnt <= (state_in != prev) ? 8'h00 : cnt + {7'h0, cnt != 8'hff};
			detect_out <= 1'b1;
			eq_done_out <= state_in == pfn_pkg::PFN_OPTIM && ready;
			align_done_out <= state_in == pfn_pkg::PFN_ALIGN && ready;
			st_done_out <= state_in == pfn_pkg::PFN_SELFTEST && ready;
			// Released field toggles so stale values never look valid
			if (in_cfg && ready && cnt < {4'h0, delay_in} + 8'h02) begin
				adv_valid_out <= 1'b1;
				adv_out <= adv_in;
			end else begin
				adv_valid_out <= 1'b0;
				adv_out <= ~adv_out;
			end
		end
	end
endmodule : pfn_peer

// [test/tb.sv]
// Bench: register tasks over AXI4-Lite, negotiation table, interrupts
// Assumes pfn_train and the peer model pfn_peer
`timescale 1ns/1ns
module tb;
	logic clock_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic local_short_in = 1'b0, local_long_in = 1'b0;
	logic detect, eq_done, align_done, st_done, adv_valid, eq_x, st_seq;
	logic cc_send, link_up, irq, seen_eq, seen_st;
	logic [31:0] remote_adv, local_adv, rd, peer_adv = 32'h0;
	logic [3:0] peer_delay = 4'h0;
	logic [2:0] state, code;
	int fail_count = 0, checks_done = 0, cycles = 0;
	logic [31:0] k_ctrl [13] = '{32'h0, 32'h8, 32'h0, 32'h0, 32'h0, 32'h0,
		32'h8, 32'h1, 32'h2, 32'h3, 32'h4, 32'h0, 32'h800};
	logic [1:0] k_loc [13] = '{2'h3, 2'h3, 2'h2, 2'h3, 2'h3, 2'h1, 2'h3,
		2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3};
	logic [31:0] k_adv [13] = '{32'hc000c000, 32'hc000c000, 32'hc000c000,
		32'h00004000, 32'h80000000, 32'h80008000, 32'h40004000, 32'h0,
		32'h0, 32'h0, 32'h0, 32'h0, 32'hc000c000};
	always #20 clock_in = ~clock_in;
	pfn_train u_pfn_train (.clock_in(clock_in), .nrst_in(nrst_in),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .local_short_in(local_short_in),
		.local_long_in(local_long_in), .signal_detect_in(detect),
		.cdr_lock_in(detect), .eq_done_in(eq_done),
		.align_done_in(align_done), .selftest_done_in(st_done),
		.remote_adv_valid_in(adv_valid), .remote_adv_in(remote_adv),
		.local_adv_out(local_adv), .state_out(state),
		.eq_exchange_out(eq_x), .selftest_seq_out(st_seq),
		.cc_send_out(cc_send), .code_out(code), .link_up_out(link_up),
		.irq_out(irq));
	pfn_peer u_pfn_peer (.clock_in(clock_in), .nrst_in(nrst_in),
		.state_in(state), .delay_in(peer_delay), .adv_in(peer_adv),
		.detect_out(detect), .eq_done_out(eq_done),
		.align_done_out(align_done), .st_done_out(st_done),
		.adv_valid_out(adv_valid), .adv_out(remote_adv));
	task give_verdict;
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			give_verdict;
		end
		if (!nrst_in) begin
			seen_eq <= 1'b0;
			seen_st <= 1'b0;
		end else begin
			if (state == pfn_pkg::PFN_OPTIM && eq_x) seen_eq <= 1'b1;
			if (state == pfn_pkg::PFN_SELFTEST && st_seq) seen_st <= 1'b1;
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp, string what);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask : check
	// Handshakes judged from settled levels before the taking edge
	task axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic done;
		logic aw_t;
		logic w_t;
		done = 1'b0;
		@(posedge clock_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(negedge clock_in);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			done = s_axi_bvalid;
			if (done) r = s_axi_bresp;
			@(posedge clock_in);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			if (done) s_axi_bready <= 1'b0;
		end
	endtask : axi_wr
	task axi_rd(input logic [3:0] a);
		logic done;
		logic ar_t;
		done = 1'b0;
		@(posedge clock_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(negedge clock_in);
			ar_t = s_axi_arvalid && s_axi_arready;
			done = s_axi_rvalid;
			if (done) begin
				rd = s_axi_rdata;
				r = s_axi_rresp;
			end
			@(posedge clock_in);
			if (ar_t) s_axi_arvalid <= 1'b0;
			if (done) s_axi_rready <= 1'b0;
		end
	endtask : axi_rd
	function automatic logic [3:0] expect_code(input logic [31:0] c,
		input logic ls, input logic ll, input logic [31:0] a);
		case (c[2:0])
			pfn_pkg::OVR_SHORT: return {1'b1, pfn_pkg::CODE_SHORT};
			pfn_pkg::OVR_LONG: return {1'b1, pfn_pkg::CODE_LONG};
			pfn_pkg::OVR_CRC: return {1'b1, pfn_pkg::CODE_CRC};
			pfn_pkg::OVR_RS: return {1'b1, pfn_pkg::CODE_RS};
			default: ;
		endcase
		if (ls && !c[3] && (a[30] | a[14])) return {1'b1, pfn_pkg::CODE_SHORT};
		if (ll && (a[31] | a[15])) return {1'b1, pfn_pkg::CODE_LONG};
		return 4'h0;
	endfunction : expect_code
	task run_case(input logic [31:0] c, input logic ls, input logic ll,
		input logic [31:0] a, input logic [3:0] dly);
		logic [3:0] e;
		logic s;
		int n;
		@(posedge clock_in);
		nrst_in <= 1'b0;
		repeat (8) @(posedge clock_in);
		nrst_in <= 1'b1;
		local_short_in <= ls;
		local_long_in <= ll;
		peer_adv <= a;
		peer_delay <= dly;
		e = expect_code(c, ls, ll, a);
		s = ls & ~c[3];
		axi_rd(pfn_pkg::ADDR_CTRL);
		check(rd, pfn_pkg::CTRL_RESET, "ctrl reset");
		axi_wr(pfn_pkg::ADDR_CTRL, c | 32'h1000);
		rd = 32'h0;
		n = 0;
		while (rd == 32'h0 && n < 300) begin
			axi_rd(pfn_pkg::ADDR_IRQ_STAT);
			n++;
		end
		check(rd, e[3] ? 32'h1 : 32'h2, "outcome");
		check(local_adv, {ll, s, 14'h0, ll, s, 14'h0}, "adv");
		check(link_up, e[3], "up");
		if (e[3]) begin
			check(code, e[2:0], "code");
			axi_rd(pfn_pkg::ADDR_STATUS);
			check({rd[7:4], rd[2:0]}, {e[2:0], 4'he}, "status");
			check(seen_eq, 1'b1, "optimize");
			check(seen_st, c[11], "selftest");
		end
		$display("Case done, mismatches %0d", fail_count);
	endtask : run_case
	task cc_count(input logic [31:0] c, input int win, input int exp);
		int n;
		axi_wr(pfn_pkg::ADDR_CTRL, c | 32'h1000);
		repeat (300) @(posedge clock_in);
		n = 0;
		repeat (win) begin
			@(posedge clock_in);
			if (cc_send) n++;
		end
		check(n, exp, "comp count");
	endtask : cc_count
	initial begin
		for (int i = 0; i < 13; i++)
			run_case(k_ctrl[i], k_loc[i][0], k_loc[i][1], k_adv[i],
				i[0] ? 4'h7 : 4'h0);
		axi_rd(4'h2);
		check(r, 2'h2, "unmapped read resp");
		check(rd, 32'h0, "unmapped read data");
		axi_wr(pfn_pkg::ADDR_STATUS, 32'hffffffff);
		check(r, 2'h2, "status write");
		check(irq, 1'b1, "irq up");
		axi_wr(pfn_pkg::ADDR_IRQ_MASK, 32'h3);
		repeat (3) @(posedge clock_in);
		check(irq, 1'b0, "irq masked");
		axi_wr(pfn_pkg::ADDR_IRQ_MASK, 32'h0);
		repeat (3) @(posedge clock_in);
		check(irq, 1'b1, "irq unmasked");
		axi_wr(pfn_pkg::ADDR_IRQ_STAT, 32'h1);
		axi_rd(pfn_pkg::ADDR_IRQ_STAT);
		check(rd, 32'h0, "irq clear");
		check(irq, 1'b0, "irq low");
		$display("Interrupt test done, mismatches %0d", fail_count);
		peer_adv <= 32'h0;
		local_short_in <= 1'b0;
		cc_count(32'h0, 128, 2);
		cc_count(32'h100, 128, 0);
		cc_count(32'h200, 256, 2);
		cc_count(32'h400, 512, 2);
		cc_count(32'h600, 64, 2);
		check(code, pfn_pkg::CODE_SHORT, "code held");
		$display("Compensation test done, mismatches %0d", fail_count);
		give_verdict;
	end
endmodule : tb
